// *** include/aacg_pkg.sv ***
/*
 * Shared constants and types of the audio converter clock generation block.
 * Assumes a single 10 MHz system clock; every slower rate is a one-cycle enable.
 */
//
// Behaviour
// - Internal master clock always runs at 256 times the sample rate.
// - Prescaler input is the external master clock or the PLL output.
// - Prescaler divides the chosen source by a programmable whole number.
// - Slave mode accepts outside audio clocks; master mode generates them.
// - Sample rate comes only from the internal master clock.
// - Master mode drives frame sync at internal master clock over 256.
// - Frame sync duty cycle follows the selected audio interface format.
// - Master bit clock derives from internal master clock, optional divider.
// - Slave mode keeps frame sync and bit clock as pure inputs.
// - PLL multiplies the reference by a fine fractional ratio.
// - Optional divide-by-two before PLL, fixed divide-by-four after it.
// - PLL fraction is 24 bits held in three 9-bit registers.
// - Slow timer tick divides the master clock per programmed rate setting.
// - Matching rate setting gives one slow timer tick every 128 ms.
// - Slow timer period scales with programmed over actual sample rate.
// - Slow timer enable resets off, forced on by either zero-cross enable.
// - Pending gain applies if zero-cross flag holds polarity for 0.25 s.

package aacg_pkg;

	// ********************************
	// Clock tree constants
	// ********************************
	localparam int unsigned MCLK_PER_SAMPLE = 256;
	localparam int unsigned PLL_POST_DIV    = 4;
	localparam int unsigned FRAC_BITS       = 24;
	localparam int unsigned FS_HALF         = 128;

	// ********************************
	// Slow timer and zero-cross timeout
	// ********************************
	localparam int unsigned SLOW_TICK_MS     = 128;
	localparam int unsigned ZC_TIMEOUT_MS    = 250;
	localparam int unsigned ZC_TIMEOUT_TICKS =
		(ZC_TIMEOUT_MS + SLOW_TICK_MS - 1) / SLOW_TICK_MS;

	// ********************************
	// Reset values
	// ********************************
	localparam logic RST_SLOW_EN = 1'b0;
	localparam logic RST_FS_PIN  = 1'b0;
	localparam logic RST_BCLK    = 1'b0;

	typedef enum logic [2:0] {
		AACG_SR_48K,
		AACG_SR_32K,
		AACG_SR_24K,
		AACG_SR_16K,
		AACG_SR_12K,
		AACG_SR_8K
	} aacg_rate_t;

	typedef enum logic {
		AACG_FMT_I2S,
		AACG_FMT_PCM
	} aacg_fmt_t;

	typedef struct packed {
		logic       master;
		logic       use_pll;
		logic       ref_div2;
		logic [3:0] prescale;
		logic [3:0] bclk_div;
		aacg_fmt_t  fmt;
		aacg_rate_t rate_sel;
	} aacg_clk_cfg_t;

	typedef struct packed {
		logic [3:0] int_part;
		logic [8:0] frac_hi;
		logic [8:0] frac_mid;
		logic [8:0] frac_lo;
	} aacg_pll_cfg_t;

	typedef struct packed {
		logic gain_zce;
		logic level_zce;
		logic alc_on;
		logic timer_req;
	} aacg_zc_cfg_t;

endpackage

// *** logic/aacg_tick_div.sv ***
/*
 * Programmable whole-number divider of an enable pulse train.
 * Assumes tick_in is a one-cycle pulse on the system clock; ratio 0 acts as 1.
 */
`timescale 1ns/10ps
`default_nettype none

module aacg_tick_div #(
	parameter int unsigned W = 4
) (
	input  wire logic         clock,    // System clock.
	input  wire logic         rst_b,    // Asynchronous reset, active low.
	input  wire logic         tick_in,  // Input enable pulse.
	input  wire logic [W-1:0] ratio,    // Division factor.
	output logic              tick_out  // One pulse every ratio input pulses.
);

	logic [W-1:0] cnt_ff;
	logic         last;

	// A ratio change takes effect at once; lowering it below the count ends the current period early.
	assign last     = (cnt_ff + W'(1) >= ratio);
	assign tick_out = tick_in & last;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cnt_ff <= '0;
		end else if (tick_in) begin
			cnt_ff <= last ? '0 : cnt_ff + W'(1);
		end
	end

endmodule

`default_nettype wire

// *** logic/aacg_clock_gen.sv ***
/*
 * Audio converter clock generation: fractional PLL model, prescaler,
 * frame sync and bit clock generation, slow timer and zero-cross timeout.
 * Assumes reference and master clock pins arrive as synchronous enable pulses.
 */
`timescale 1ns/10ps
`default_nettype none

module aacg_clock_gen #(
	parameter int unsigned SLOW_MS = aacg_pkg::SLOW_TICK_MS
) (
	input  wire logic                    clock,         // 10 MHz system clock.
	input  wire logic                    rst_b,         // Async reset, active low.
	input  wire aacg_pkg::aacg_clk_cfg_t clk_cfg,       // Clock tree settings.
	input  wire aacg_pkg::aacg_pll_cfg_t pll_cfg,       // PLL multiplier.
	input  wire aacg_pkg::aacg_zc_cfg_t  zc_cfg,        // Zero-cross settings.
	input  wire logic                    mclk_tick,     // Master clock pin pulse.
	input  wire logic                    ref_tick,      // PLL reference pulse.
	input  wire logic                    fs_in,         // Frame sync pin level.
	input  wire logic                    bclk_in,       // Bit clock pin level.
	input  wire logic                    zc_flag,       // Zero-cross flag level.
	input  wire logic                    gain_req,      // New gain pending pulse.
	output logic                         internal_master_clock, // Master clk pulse.
	output logic                         sample_tick,   // Converter sample pulse.
	output logic                         frame_sync_o,  // Frame sync drive.
	output logic                         frame_sync_oe, // Frame sync enable.
	output logic                         bclk_o,        // Bit clock drive.
	output logic                         bclk_oe,       // Bit clock enable.
	output logic                         fs_seen,       // Frame sync level seen.
	output logic                         bclk_seen,     // Bit clock level seen.
	output logic                         slow_timer_enable, // Slow timer on.
	output logic                         slow_tick,     // Slow timer pulse.
	output logic                         gain_apply     // Apply pending gain.
);

	// ********************************
	// PLL model
	// ********************************
	localparam int unsigned FB = aacg_pkg::FRAC_BITS;

	logic          ref_half_ff;
	logic          pll_in_tick;
	logic [FB-1:0] frac;
	logic [FB-1:0] acc_ff;
	logic [FB:0]   acc_sum;
	logic [4:0]    pend_ff;
	logic [4:0]    nxt_pend;
	logic          osc_tick;
	logic          pll_tick;

	assign frac        = {pll_cfg.frac_hi[5:0], pll_cfg.frac_mid, pll_cfg.frac_lo};
	assign pll_in_tick = ref_tick & (!clk_cfg.ref_div2 | ref_half_ff);
	assign acc_sum     = {1'b0, acc_ff} + {1'b0, frac};
	assign osc_tick    = (pend_ff != 5'h0);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ref_half_ff <= 1'b0;
		end else if (ref_tick) begin
			ref_half_ff <= !ref_half_ff;
		end
	end

	// Each PLL input pulse owes int + frac/2^24 oscillator pulses; the owed
	// whole pulses are paid out one per system cycle.
	always_comb begin
		nxt_pend = pend_ff - (osc_tick ? 5'h1 : 5'h0);
		if (pll_in_tick) begin
			nxt_pend = nxt_pend + {1'b0, pll_cfg.int_part} + {4'h0, acc_sum[FB]};
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			acc_ff  <= '0;
			pend_ff <= '0;
		end else begin
			pend_ff <= nxt_pend;
			if (pll_in_tick) begin
				acc_ff <= acc_sum[FB-1:0];
			end
		end
	end

	aacg_tick_div #(
		.W (3)
	) u_post_div (
		.clock    (clock),
		.rst_b    (rst_b),
		.tick_in  (osc_tick),
		.ratio    (3'(aacg_pkg::PLL_POST_DIV)),
		.tick_out (pll_tick)
	);

	// ********************************
	// Source select and prescaler
	// ********************************
	logic src_tick;

	assign src_tick = clk_cfg.use_pll ? pll_tick : mclk_tick;

	aacg_tick_div #(
		.W (4)
	) u_prescale (
		.clock    (clock),
		.rst_b    (rst_b),
		.tick_in  (src_tick),
		.ratio    (clk_cfg.prescale),
		.tick_out (internal_master_clock)
	);

	// ********************************
	// Sample rate, frame sync, bit clock
	// ********************************
	logic [7:0] fs_cnt_ff;
	logic       fs_out_ff;
	logic       nxt_fs;
	logic       bclk_ff;
	logic       bclk_half;

	// The converter rate counts the internal master clock only; pin activity
	// from the frame sync and bit clock inputs never reaches this counter.
	assign sample_tick = internal_master_clock & (fs_cnt_ff == 8'hff);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			fs_cnt_ff <= '0;
		end else if (internal_master_clock) begin
			fs_cnt_ff <= fs_cnt_ff + 8'h1;
		end
	end

	always_comb begin
		if (clk_cfg.fmt == aacg_pkg::AACG_FMT_I2S) begin
			nxt_fs = (fs_cnt_ff >= 8'(aacg_pkg::FS_HALF));
		end else begin
			nxt_fs = (fs_cnt_ff < {3'h0, clk_cfg.bclk_div, 1'b0});
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			fs_out_ff <= aacg_pkg::RST_FS_PIN;
		end else begin
			fs_out_ff <= nxt_fs;
		end
	end

	aacg_tick_div #(
		.W (4)
	) u_bclk_div (
		.clock    (clock),
		.rst_b    (rst_b),
		.tick_in  (internal_master_clock),
		.ratio    (clk_cfg.bclk_div),
		.tick_out (bclk_half)
	);

	// The bit clock restarts low with the frame so edges stay frame aligned.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			bclk_ff <= aacg_pkg::RST_BCLK;
		end else if (sample_tick) begin
			bclk_ff <= 1'b0;
		end else if (bclk_half) begin
			bclk_ff <= !bclk_ff;
		end
	end

	assign frame_sync_o  = fs_out_ff;
	assign bclk_o        = bclk_ff;
	assign frame_sync_oe = clk_cfg.master;
	assign bclk_oe       = clk_cfg.master;

	// In slave mode the pins are only observed; the system must keep them
	// locked to the master clock source.
	logic fs_seen_ff;
	logic bclk_seen_ff;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			fs_seen_ff   <= 1'b0;
			bclk_seen_ff <= 1'b0;
		end else begin
			fs_seen_ff   <= fs_in;
			bclk_seen_ff <= bclk_in;
		end
	end

	assign fs_seen   = fs_seen_ff;
	assign bclk_seen = bclk_seen_ff;

	// ********************************
	// Slow timer
	// ********************************
	logic        slow_en_ff;
	logic [13:0] slow_cnt_ff;
	logic [13:0] slow_limit;
	logic        zc_on;

	assign zc_on = zc_cfg.gain_zce | zc_cfg.level_zce;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			slow_en_ff <= aacg_pkg::RST_SLOW_EN;
		end else begin
			slow_en_ff <= zc_cfg.timer_req | zc_on;
		end
	end

	// Samples per slow tick follow the programmed rate; a wrong setting scales
	// the period by programmed over actual rate.
	always_comb begin
		case (clk_cfg.rate_sel)
			aacg_pkg::AACG_SR_48K: slow_limit = 14'(48 * SLOW_MS);
			aacg_pkg::AACG_SR_32K: slow_limit = 14'(32 * SLOW_MS);
			aacg_pkg::AACG_SR_24K: slow_limit = 14'(24 * SLOW_MS);
			aacg_pkg::AACG_SR_16K: slow_limit = 14'(16 * SLOW_MS);
			aacg_pkg::AACG_SR_12K: slow_limit = 14'(12 * SLOW_MS);
			aacg_pkg::AACG_SR_8K:  slow_limit = 14'(8 * SLOW_MS);
			default:               slow_limit = 14'(48 * SLOW_MS);
		endcase
	end

	assign slow_tick = slow_en_ff & sample_tick & (slow_cnt_ff + 14'h1 >= slow_limit);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			slow_cnt_ff <= '0;
		end else if (!slow_en_ff) begin
			slow_cnt_ff <= '0;
		end else if (sample_tick) begin
			slow_cnt_ff <= slow_tick ? 14'h0 : slow_cnt_ff + 14'h1;
		end
	end

	assign slow_timer_enable = slow_en_ff;

	// ********************************
	// Zero-cross gated gain update
	// ********************************
	typedef enum logic {
		ZC_IDLE,
		ZC_WAIT
	} aacg_zc_state_t;

	aacg_zc_state_t zc_state_ff;
	logic [1:0]     zc_ticks_ff;
	logic           zc_prev_ff;
	logic           zc_active;
	logic           zc_toggle;
	logic           zc_timeout;
	logic           apply_ff;

	assign zc_active  = zc_cfg.alc_on ? zc_cfg.level_zce : zc_cfg.gain_zce;
	assign zc_toggle  = (zc_flag != zc_prev_ff);
	assign zc_timeout = slow_en_ff & slow_tick &
		(zc_ticks_ff + 2'h1 >= 2'(aacg_pkg::ZC_TIMEOUT_TICKS));

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			zc_prev_ff <= 1'b0;
		end else begin
			zc_prev_ff <= zc_flag;
		end
	end

	// A new request while waiting restarts the timeout window.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			zc_state_ff <= ZC_IDLE;
			zc_ticks_ff <= '0;
			apply_ff    <= 1'b0;
		end else begin
			apply_ff <= 1'b0;
			case (zc_state_ff)
				ZC_IDLE: begin
					zc_ticks_ff <= '0;
					if (gain_req && !zc_active) begin
						apply_ff <= 1'b1;
					end else if (gain_req) begin
						zc_state_ff <= ZC_WAIT;
					end
				end
				ZC_WAIT: begin
					if (gain_req) begin
						zc_ticks_ff <= '0;
					end else if (zc_toggle || zc_timeout || !zc_active) begin
						apply_ff    <= 1'b1;
						zc_state_ff <= ZC_IDLE;
					end else if (slow_tick) begin
						zc_ticks_ff <= zc_ticks_ff + 2'h1;
					end
				end
				default: begin
					zc_state_ff <= ZC_IDLE;
				end
			endcase
		end
	end

	assign gain_apply = apply_ff;

	// ********************************
	// Checks
	// ********************************
	property p_sample_period;
		@(posedge clock) disable iff (!rst_b)
		sample_tick |=> (fs_cnt_ff == 8'h00);
	endproperty
	a_sample_period: assert property (p_sample_period)
		else $error("sample pulse not at counter wrap");

	property p_slave_pins;
		@(posedge clock) disable iff (!rst_b)
		!clk_cfg.master |-> (!frame_sync_oe && !bclk_oe)
			##1 (fs_seen == $past(fs_in) && bclk_seen == $past(bclk_in));
	endproperty
	a_slave_pins: assert property (p_slave_pins)
		else $error("slave pin driven or not observed");

	property p_master_fs;
		@(posedge clock) disable iff (!rst_b)
		(clk_cfg.master && clk_cfg.fmt == aacg_pkg::AACG_FMT_I2S &&
			fs_cnt_ff == 8'(aacg_pkg::FS_HALF)) |-> frame_sync_oe ##1 frame_sync_o;
	endproperty
	a_master_fs: assert property (p_master_fs)
		else $error("frame sync not raised at mid frame");

	property p_src_mclk;
		@(posedge clock) disable iff (!rst_b)
		(!clk_cfg.use_pll && mclk_tick && clk_cfg.prescale == 4'h1) |-> internal_master_clock;
	endproperty
	a_src_mclk: assert property (p_src_mclk)
		else $error("master clock pin not reaching prescaler");

	property p_osc_drain;
		@(posedge clock) disable iff (!rst_b)
		(osc_tick && !pll_in_tick) |=> (pend_ff == $past(pend_ff) - 5'h1);
	endproperty
	a_osc_drain: assert property (p_osc_drain)
		else $error("oscillator pulses not paid out");

	property p_slow_enable;
		@(posedge clock) disable iff (!rst_b)
		zc_on |=> slow_timer_enable;
	endproperty
	a_slow_enable: assert property (p_slow_enable)
		else $error("slow timer not forced on");

	property p_i2s_duty;
		@(posedge clock) disable iff (!rst_b)
		(clk_cfg.fmt == aacg_pkg::AACG_FMT_I2S && fs_cnt_ff == 8'h00) |=> !frame_sync_o;
	endproperty
	a_i2s_duty: assert property (p_i2s_duty)
		else $error("frame sync high in first half");

	property p_timeout_apply;
		@(posedge clock) disable iff (!rst_b)
		(zc_state_ff == ZC_WAIT && !gain_req && zc_timeout) |=> gain_apply;
	endproperty
	a_timeout_apply: assert property (p_timeout_apply)
		else $error("timeout did not apply gain");

	property p_slow_wrap;
		@(posedge clock) disable iff (!rst_b)
		slow_tick |=> (slow_cnt_ff == 14'h0);
	endproperty
	a_slow_wrap: assert property (p_slow_wrap)
		else $error("slow timer did not wrap");

endmodule

`default_nettype wire

// *** testbench/aacg_far_side.sv ***
/*
 * Far-side model: master clock pin, PLL reference and slave-mode audio host.
 * Assumes the bench samples its outputs on the same system clock.
 */
`timescale 1ns/10ps
`default_nettype none

module aacg_far_side #(
	parameter int unsigned REF_GAP = 16
) (
	input  wire logic clock,     // System clock.
	input  wire logic rst_b,     // Reset, active low.
	input  wire logic run,       // Produce clock pulses.
	output logic      mclk_tick, // Master clock pin pulse.
	output logic      ref_tick,  // PLL reference pulse.
	output logic      host_fs,   // Host frame sync level.
	output logic      host_bclk  // Host bit clock level.
);
	logic [9:0] ph_ff;
	logic [7:0] gap_ff;

	// One phase counter feeds both host pin levels, so they stay on one reference.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ph_ff <= 10'h000;
		end else begin
			ph_ff <= ph_ff + 10'h001;
		end
	end

	// Wide pulse spacing leaves room for the largest multiplier.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			gap_ff <= 8'h00;
		end else if (gap_ff == 8'(REF_GAP - 1)) begin
			gap_ff <= 8'h00;
		end else begin
			gap_ff <= gap_ff + 8'h01;
		end
	end

	assign mclk_tick = run;
	assign ref_tick  = run && (gap_ff == 8'h00);
	assign host_fs   = ph_ff[8];
	assign host_bclk = ph_ff[2];
endmodule

`default_nettype wire

// *** testbench/tb.sv ***
/*
 * Self-checking bench of the clock generation block.
 * Assumes the far-side model and a shortened slow timer (one ms per tick).
 */
`timescale 1ns/10ps
`default_nettype none

module tb;
	logic                    clock = 1'b0;
	logic                    rst_b = 1'b0;
	aacg_pkg::aacg_clk_cfg_t clk_cfg;
	aacg_pkg::aacg_pll_cfg_t pll_cfg;
	aacg_pkg::aacg_zc_cfg_t  zc_cfg;
	logic                    zc_flag;
	logic                    gain_req;
	logic                    run;
	logic                    mclk_tick, ref_tick, host_fs, host_bclk, fs_in, bclk_in;
	logic                    mclk_int, sample_tick, fs_o, fs_oe, bclk_o, bclk_oe;
	logic                    fs_seen, bclk_seen, slow_en, slow_tick, gain_apply;
	logic                    fs_q, bc_q;
	int failures    = 0;
	int check_count = 0;
	int cyc = 0, imc = 0, s_at = 0, s_gap = 0, f_at = 0, f_gap = 0, hi = 0, hi_last = 0;
	int bc = 0, bc_last = 0, sc_at = 0, sc_gap = 0, sl_at = 0, sl_gap = 0;

	always #50 clock = ~clock;

	// The pin level is whoever drives it: the block in master mode, else the host.
	assign fs_in   = fs_oe ? fs_o : host_fs;
	assign bclk_in = bclk_oe ? bclk_o : host_bclk;

	aacg_far_side far (.clock(clock), .rst_b(rst_b), .run(run), .mclk_tick(mclk_tick),
		.ref_tick(ref_tick), .host_fs(host_fs), .host_bclk(host_bclk));

	aacg_clock_gen #(.SLOW_MS(1)) dut (.clock(clock), .rst_b(rst_b), .clk_cfg(clk_cfg),
		.pll_cfg(pll_cfg), .zc_cfg(zc_cfg), .mclk_tick(mclk_tick), .ref_tick(ref_tick),
		.fs_in(fs_in), .bclk_in(bclk_in), .zc_flag(zc_flag), .gain_req(gain_req),
		.internal_master_clock(mclk_int), .sample_tick(sample_tick), .frame_sync_o(fs_o),
		.frame_sync_oe(fs_oe), .bclk_o(bclk_o), .bclk_oe(bclk_oe), .fs_seen(fs_seen),
		.bclk_seen(bclk_seen), .slow_timer_enable(slow_en), .slow_tick(slow_tick),
		.gain_apply(gain_apply));

	// ********************************
	// Monitor of rates and duty
	// ********************************
	always @(posedge clock) begin
		cyc <= cyc + 1;
		fs_q <= fs_o;
		bc_q <= bclk_o;
		if (mclk_int) imc <= imc + 1;
		if (sample_tick) begin
			s_gap <= imc - s_at;
			s_at <= imc;
			sc_gap <= cyc - sc_at;
			sc_at <= cyc;
		end
		if (slow_tick) begin
			sl_gap <= cyc - sl_at;
			sl_at <= cyc;
		end
		if (fs_o && !fs_q) begin
			f_gap <= imc - f_at;
			f_at <= imc;
			hi_last <= hi;
			hi <= int'(mclk_int);
			bc_last <= bc;
			bc <= int'(bclk_o && !bc_q);
		end else begin
			if (fs_o && mclk_int) hi <= hi + 1;
			if (bclk_o && !bc_q) bc <= bc + 1;
		end
		if (cyc == 90000) begin
			failures++;
			test_done();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t: got %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic set_clk(input logic m, input logic p, input logic d2, input logic [3:0] pre,
			input aacg_pkg::aacg_fmt_t fmt, input aacg_pkg::aacg_rate_t rate);
		@(posedge clock);
		clk_cfg <= '{m, p, d2, pre, 4'h2, fmt, rate};
	endtask

	task automatic wait_apply(output int d);
		d = 0;
		while (gain_apply !== 1'b1 && d < 4200) begin
			@(posedge clock) #1;
			d++;
		end
	endtask

	task automatic t_master(input aacg_pkg::aacg_fmt_t fmt);
		set_clk(1'b1, 1'b0, 1'b0, 4'h2, fmt, aacg_pkg::AACG_SR_48K);
		repeat (1700) @(posedge clock);
		check(s_gap, 256);
		check(sc_gap, 512);
		check(f_gap, 256);
		check(hi_last, (fmt == aacg_pkg::AACG_FMT_I2S) ? 128 : 4);
		check(bc_last, 64);
		check({fs_oe, bclk_oe}, 2'b11);
	endtask

	task automatic t_slave();
		logic [1:0] v;
		set_clk(1'b0, 1'b0, 1'b0, 4'h1, aacg_pkg::AACG_FMT_I2S, aacg_pkg::AACG_SR_48K);
		repeat (800) @(posedge clock);
		check({fs_oe, bclk_oe}, 2'b00);
		check(sc_gap, 256);
		for (int i = 0; i < 8; i++) begin
			@(posedge clock);
			v = {fs_in, bclk_in};
			#1 check({fs_seen, bclk_seen}, v);
		end
	endtask

	task automatic t_pll(input logic d2, input logic [3:0] ip, input logic [23:0] fr,
			input int e);
		int a;
		set_clk(1'b1, 1'b1, d2, 4'h1, aacg_pkg::AACG_FMT_I2S, aacg_pkg::AACG_SR_48K);
		pll_cfg <= '{ip, {3'h0, fr[23:18]}, fr[17:9], fr[8:0]};
		repeat (40) @(posedge clock);
		a = imc;
		repeat (1024) @(posedge clock);
		check((imc - a >= e - 1) && (imc - a <= e + 1), 1'b1);
	endtask

	task automatic t_slow();
		set_clk(1'b0, 1'b0, 1'b0, 4'h1, aacg_pkg::AACG_FMT_I2S, aacg_pkg::AACG_SR_48K);
		zc_cfg <= '{1'b1, 1'b0, 1'b0, 1'b0};
		repeat (4) @(posedge clock);
		check(slow_en, 1'b1);
		repeat (24700) @(posedge clock);
		check(sl_gap, 12288);
		set_clk(1'b0, 1'b0, 1'b0, 4'h1, aacg_pkg::AACG_FMT_I2S, aacg_pkg::AACG_SR_16K);
		repeat (8400) @(posedge clock);
		check(sl_gap, 4096);
		set_clk(1'b0, 1'b0, 1'b0, 4'h1, aacg_pkg::AACG_FMT_I2S, aacg_pkg::AACG_SR_8K);
		repeat (6300) @(posedge clock);
		check(sl_gap, 2048);
	endtask

	task automatic t_zc();
		int d;
		@(posedge clock);
		gain_req <= 1'b1;
		@(posedge clock);
		gain_req <= 1'b0;
		wait_apply(d);
		check((d > 2040) && (d < 4200), 1'b1);
		@(posedge clock);
		zc_cfg <= '{1'b0, 1'b1, 1'b1, 1'b0};
		gain_req <= 1'b1;
		@(posedge clock);
		gain_req <= 1'b0;
		repeat (5) @(posedge clock);
		zc_flag <= 1'b1;
		wait_apply(d);
		check(d, 1);
		@(posedge clock);
		zc_cfg <= '{1'b0, 1'b0, 1'b0, 1'b0};
		gain_req <= 1'b1;
		@(posedge clock);
		gain_req <= 1'b0;
		// The apply pulse stands only for the cycle after the request edge.
		#1 check(gain_apply, 1'b1);
		@(posedge clock) #1 check(gain_apply, 1'b0);
		@(posedge clock);
		zc_cfg <= '{1'b0, 1'b0, 1'b0, 1'b1};
		repeat (3) @(posedge clock);
		check(slow_en, 1'b1);
		zc_cfg <= '{1'b0, 1'b0, 1'b0, 1'b0};
		repeat (3) @(posedge clock);
		check(slow_en, 1'b0);
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	initial begin
		clk_cfg = '0;
		pll_cfg = '0;
		zc_cfg = '0;
		zc_flag = 1'b0;
		gain_req = 1'b0;
		run = 1'b0;
		repeat (10) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock) #1;
		check({slow_en, gain_apply, fs_o, bclk_o}, 4'h0);
		@(posedge clock);
		run <= 1'b1;
		t_master(aacg_pkg::AACG_FMT_I2S);
		t_master(aacg_pkg::AACG_FMT_PCM);
		t_slave();
		t_pll(1'b0, 4'h8, 24'h00_0000, 128);
		t_pll(1'b1, 4'h8, 24'h00_0000, 64);
		t_pll(1'b0, 4'h6, 24'h80_0000, 104);
		t_pll(1'b0, 4'hc, 24'h31_26e9, 195);
		t_slow();
		t_zc();
		test_done();
	end
endmodule

`default_nettype wire
